// *** core/sfr_bank1_consts.svh ***
// Offsets, field positions and reset values of the bank-one register file.
// Assumes inclusion by bare name; byte address is four times the index.
`ifndef SFR_BANK1_CONSTS_SVH
`define SFR_BANK1_CONSTS_SVH
`define IDX_INDIRECT_PORT 8'h80
`define IDX_OPTION_CONTROL 8'h81
`define IDX_PC_LOW_BYTE 8'h82
`define IDX_CORE_STATUS 8'h83
`define IDX_INDIRECT_POINTER 8'h84
`define IDX_PORT_A_DIRECTION 8'h85
`define IDX_PORT_B_DIRECTION 8'h86
`define IDX_PORT_C_DIRECTION 8'h87
`define IDX_PC_HIGH_LATCH 8'h8a
`define IDX_INTERRUPT_CONTROL 8'h8b
`define IDX_PERIPHERAL_IRQ_ENABLE 8'h8c
`define IDX_POWER_RESET_STATUS 8'h8e
`define IDX_TIMER2_PERIOD 8'h92
`define IDX_SERIAL_SLAVE_ADDRESS 8'h93
`define IDX_SERIAL_PORT_STATUS 8'h94
`define IDX_RESET_CAUSE 8'ha0
`define BANK_INDEX_MASK 8'h7f
`define RST_OPTION_CONTROL 8'hff
`define RST_PORT_A_DIRECTION 8'h3f
`define RST_PORT_B_DIRECTION 8'hff
`define RST_PORT_C_DIRECTION 8'hff
`define RST_TIMER2_PERIOD 8'hff
`define RST_ZERO 8'h00
`define RST_STATUS_POWER 8'h18
`define MASK_STATUS_OTHER 8'h07
`define MASK_PORT_A 8'h3f
`define MASK_PC_HIGH 8'h1f
`define MASK_PIE 8'hff
`define MASK_POWER_RESET_STATUS 8'h03
`define MASK_SERIAL_PORT_STATUS 8'h3f
`define MASK_STATUS_RW 8'he7
`define BIT_STATUS_TO 4
`define BIT_STATUS_PD 3
`define BIT_POWER_RESET_STATUS_POR 1
`define BIT_POWER_RESET_STATUS_BOR 0
`define INTERRUPT_CONTROL_RST_MASK 8'h01
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// *** core/sfr_bank1_pkg.sv ***
// Types shared by the bank-one register file and its read path.
// Assumes no other package.
package sfr_bank1_pkg;
    typedef enum logic [1:0] {
        RST_NONE = 2'b00,
        RST_POWER = 2'b01,
        RST_BROWNOUT = 2'b11,
        RST_OTHER = 2'b10
    } reset_kind_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRESP = 2'b01,
        ST_RRESP = 2'b10
    } bus_state_e;

    typedef struct packed {
        logic [7:0] option_control;
        logic [7:0] pc_low_byte;
        logic [7:0] core_status;
        logic [7:0] indirect_pointer;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] port_c_direction;
        logic [7:0] pc_high_latch;
        logic [7:0] interrupt_control;
        logic [7:0] peripheral_irq_enable;
        logic [7:0] power_reset_status;
        logic [7:0] timer2_period;
        logic [7:0] serial_slave_address;
    } regs_s;

    typedef struct packed {
        logic mem_req;
        logic mem_we;
        logic [7:0] mem_addr;
        logic [7:0] mem_wdata;
    } mem_req_s;

    typedef struct packed {
        bus_state_e state;
        regs_s regs;
        logic [12:0] pc;
        logic wdone;
        logic [7:0] widx;
        logic [31:0] wdat;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] last_kind;
        logic mem_wait;
        logic mem_is_read;
    } state_s;
endpackage

// *** core/sfr_read_mux.sv ***
// Read decode of the bank-one register file.
// Assumes the register image and peripheral status come from the same clock.
`timescale 1ns/1ps
`include "sfr_bank1_consts.svh"
module sfr_read_mux (
    input wire logic [7:0] idx,
    input wire sfr_bank1_pkg::regs_s regs,
    input wire logic [7:0] serial_status,
    output logic [7:0] rdata,
    output logic hit
);
    always_comb begin
        rdata = `RST_ZERO;
        hit = 1'b1;
        case (idx & `BANK_INDEX_MASK)
            (`IDX_OPTION_CONTROL & `BANK_INDEX_MASK): rdata = regs.option_control;
            (`IDX_PC_LOW_BYTE & `BANK_INDEX_MASK): rdata = regs.pc_low_byte;
            (`IDX_CORE_STATUS & `BANK_INDEX_MASK): rdata = regs.core_status;
            (`IDX_INDIRECT_POINTER & `BANK_INDEX_MASK): rdata = regs.indirect_pointer;
            (`IDX_PORT_A_DIRECTION & `BANK_INDEX_MASK): rdata = regs.port_a_direction;
            (`IDX_PORT_B_DIRECTION & `BANK_INDEX_MASK): rdata = regs.port_b_direction;
            (`IDX_PORT_C_DIRECTION & `BANK_INDEX_MASK): rdata = regs.port_c_direction;
            (`IDX_PC_HIGH_LATCH & `BANK_INDEX_MASK): rdata = regs.pc_high_latch;
            (`IDX_INTERRUPT_CONTROL & `BANK_INDEX_MASK): rdata = regs.interrupt_control;
            (`IDX_PERIPHERAL_IRQ_ENABLE & `BANK_INDEX_MASK): rdata = regs.peripheral_irq_enable;
            (`IDX_POWER_RESET_STATUS & `BANK_INDEX_MASK): rdata = regs.power_reset_status;
            (`IDX_TIMER2_PERIOD & `BANK_INDEX_MASK): rdata = regs.timer2_period;
            (`IDX_SERIAL_SLAVE_ADDRESS & `BANK_INDEX_MASK): rdata = regs.serial_slave_address;
            (`IDX_SERIAL_PORT_STATUS & `BANK_INDEX_MASK): rdata = serial_status & `MASK_SERIAL_PORT_STATUS;
            default: hit = 1'b0;
        endcase
    end
endmodule

// *** core/sfr_bank1_decode.sv ***
// Bank-one special-function register file behind an AXI4-Lite slave.
// Assumes one clock; indirect accesses go out on a data-memory port.
// How it works
// - Writing the low pc byte loads pc upper bits from the high latch.
// - Upper pc bits have no bus path; only the high latch reaches them.
// - Shared core registers answer at bank-zero and bank-one indices alike.
// - Unimplemented indices and bits read zero; writes to them are dropped.
// - Pin and watchdog resets load the other-reset values, not power values.
`timescale 1ns/1ps
`include "sfr_bank1_consts.svh"
module sfr_bank1_decode (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_on_reset,
    input wire logic brownout_reset,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output sfr_bank1_pkg::mem_req_s mem_req,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] serial_status,
    output logic [12:0] program_counter,
    output logic [7:0] option_control,
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_c_direction,
    output logic [7:0] peripheral_irq_enable,
    output logic [7:0] timer2_period,
    output logic [7:0] serial_slave_address
);
    sfr_bank1_pkg::state_s s_r;
    sfr_bank1_pkg::state_s s_nxt;
    logic por_s1_r;
    logic por_s2_r;
    logic bor_s1_r;
    logic bor_s2_r;
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic rd_hit;
    logic [7:0] wr_idx;
    logic [7:0] wv;
    logic do_write;
    logic ind_write;
    sfr_bank1_pkg::reset_kind_e kind;

    // Reset-cause inputs come from pins
    always_ff @(posedge aclk) begin
        por_s1_r <= power_on_reset;
        por_s2_r <= por_s1_r;
        bor_s1_r <= brownout_reset;
        bor_s2_r <= bor_s1_r;
    end

    always_comb begin
        if (por_s2_r) begin
            kind = sfr_bank1_pkg::RST_POWER;
        end else if (bor_s2_r) begin
            kind = sfr_bank1_pkg::RST_BROWNOUT;
        end else begin
            kind = sfr_bank1_pkg::RST_OTHER;
        end
    end

    assign rd_idx = s_axi_araddr[9:2];

    sfr_read_mux u_read_mux (
        .idx(rd_idx),
        .regs(s_r.regs),
        .serial_status(serial_status),
        .rdata(rd_val),
        .hit(rd_hit)
    );

    assign s_axi_awready = (s_r.state == sfr_bank1_pkg::ST_IDLE) && !s_r.wdone
        && s_axi_awvalid && s_axi_wvalid && !s_r.mem_wait;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = (s_r.state == sfr_bank1_pkg::ST_IDLE) && !s_axi_awready
        && s_axi_arvalid && !s_r.mem_wait;
    assign s_axi_bvalid = (s_r.state == sfr_bank1_pkg::ST_WRESP);
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = (s_r.state == sfr_bank1_pkg::ST_RRESP);
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    assign wr_idx = s_axi_awaddr[9:2];
    assign wv = s_axi_wdata[7:0];
    assign do_write = s_axi_awready && s_axi_wstrb[0];
    assign ind_write = do_write && ((wr_idx & `BANK_INDEX_MASK)
        == (`IDX_INDIRECT_PORT & `BANK_INDEX_MASK));

    // Indirect port requests toward data memory
    always_comb begin
        mem_req.mem_req = s_r.mem_wait;
        mem_req.mem_we = !s_r.mem_is_read;
        mem_req.mem_addr = s_r.regs.indirect_pointer;
        mem_req.mem_wdata = s_r.wdat[7:0];
    end

    always_comb begin
        s_nxt = s_r;
        case (s_r.state)
            sfr_bank1_pkg::ST_IDLE: begin
                if (s_r.mem_wait) begin
                    if (mem_ack) begin
                        s_nxt.mem_wait = 1'b0;
                        if (s_r.mem_is_read) begin
                            s_nxt.rdata = {24'h000000, mem_rdata};
                            s_nxt.state = sfr_bank1_pkg::ST_RRESP;
                        end else begin
                            s_nxt.state = sfr_bank1_pkg::ST_WRESP;
                        end
                    end
                end else if (s_axi_awready) begin
                    s_nxt.bresp = `RESP_OKAY;
                    s_nxt.wdat = s_axi_wdata;
                    s_nxt.widx = wr_idx;
                    s_nxt.state = sfr_bank1_pkg::ST_WRESP;
                    if (ind_write) begin
                        s_nxt.mem_wait = 1'b1;
                        s_nxt.mem_is_read = 1'b0;
                        s_nxt.state = sfr_bank1_pkg::ST_IDLE;
                        s_nxt.wdone = 1'b1;
                    end else if (do_write) begin
                        case (wr_idx & `BANK_INDEX_MASK)
                            (`IDX_OPTION_CONTROL & `BANK_INDEX_MASK):
                                s_nxt.regs.option_control = wv;
                            (`IDX_PC_LOW_BYTE & `BANK_INDEX_MASK): begin
                                s_nxt.regs.pc_low_byte = wv;
                                s_nxt.pc = {s_r.regs.pc_high_latch[4:0], wv};
                            end
                            (`IDX_CORE_STATUS & `BANK_INDEX_MASK):
                                s_nxt.regs.core_status = (s_r.regs.core_status
                                    & ~`MASK_STATUS_RW) | (wv & `MASK_STATUS_RW);
                            (`IDX_INDIRECT_POINTER & `BANK_INDEX_MASK):
                                s_nxt.regs.indirect_pointer = wv;
                            (`IDX_PORT_A_DIRECTION & `BANK_INDEX_MASK):
                                s_nxt.regs.port_a_direction = wv & `MASK_PORT_A;
                            (`IDX_PORT_B_DIRECTION & `BANK_INDEX_MASK):
                                s_nxt.regs.port_b_direction = wv;
                            (`IDX_PORT_C_DIRECTION & `BANK_INDEX_MASK):
                                s_nxt.regs.port_c_direction = wv;
                            (`IDX_PC_HIGH_LATCH & `BANK_INDEX_MASK):
                                s_nxt.regs.pc_high_latch = wv & `MASK_PC_HIGH;
                            (`IDX_INTERRUPT_CONTROL & `BANK_INDEX_MASK):
                                s_nxt.regs.interrupt_control = wv;
                            (`IDX_PERIPHERAL_IRQ_ENABLE & `BANK_INDEX_MASK):
                                s_nxt.regs.peripheral_irq_enable = wv & `MASK_PIE;
                            (`IDX_POWER_RESET_STATUS & `BANK_INDEX_MASK):
                                s_nxt.regs.power_reset_status = wv & `MASK_POWER_RESET_STATUS;
                            (`IDX_TIMER2_PERIOD & `BANK_INDEX_MASK):
                                s_nxt.regs.timer2_period = wv;
                            (`IDX_SERIAL_SLAVE_ADDRESS & `BANK_INDEX_MASK):
                                s_nxt.regs.serial_slave_address = wv;
                            default: s_nxt.bresp = `RESP_OKAY;
                        endcase
                    end
                end else if (s_axi_arready) begin
                    s_nxt.rresp = `RESP_OKAY;
                    if (rd_idx == `IDX_RESET_CAUSE) begin
                        s_nxt.rdata = {30'h0, s_r.last_kind};
                        s_nxt.state = sfr_bank1_pkg::ST_RRESP;
                    end else if ((rd_idx & `BANK_INDEX_MASK)
                        == (`IDX_INDIRECT_PORT & `BANK_INDEX_MASK)) begin
                        s_nxt.mem_wait = 1'b1;
                        s_nxt.mem_is_read = 1'b1;
                    end else begin
                        s_nxt.rdata = {24'h000000, rd_hit ? rd_val : `RST_ZERO};
                        s_nxt.state = sfr_bank1_pkg::ST_RRESP;
                    end
                end
            end
            sfr_bank1_pkg::ST_WRESP: begin
                if (s_axi_bready) begin
                    s_nxt.state = sfr_bank1_pkg::ST_IDLE;
                    s_nxt.wdone = 1'b0;
                end
            end
            sfr_bank1_pkg::ST_RRESP: begin
                if (s_axi_rready) begin
                    s_nxt.state = sfr_bank1_pkg::ST_IDLE;
                end
            end
            default: s_nxt.state = sfr_bank1_pkg::ST_IDLE;
        endcase
        if (s_r.wdone && !s_r.mem_wait && s_r.state == sfr_bank1_pkg::ST_IDLE) begin
            s_nxt.wdone = 1'b0;
        end
    end

    // Power and brown-out load full reset values; pin and watchdog keep pointer and reset status, status bits 2:0 and interrupt-control bit 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r.state <= sfr_bank1_pkg::ST_IDLE;
            s_r.wdone <= 1'b0;
            s_r.widx <= `RST_ZERO;
            s_r.wdat <= 32'h00000000;
            s_r.wstrb <= 4'h0;
            s_r.bresp <= `RESP_OKAY;
            s_r.rdata <= 32'h00000000;
            s_r.rresp <= `RESP_OKAY;
            s_r.mem_wait <= 1'b0;
            s_r.mem_is_read <= 1'b0;
            s_r.pc <= 13'h0;
            s_r.last_kind <= kind;
            s_r.regs.option_control <= `RST_OPTION_CONTROL;
            s_r.regs.pc_low_byte <= `RST_ZERO;
            s_r.regs.port_a_direction <= `RST_PORT_A_DIRECTION;
            s_r.regs.port_b_direction <= `RST_PORT_B_DIRECTION;
            s_r.regs.port_c_direction <= `RST_PORT_C_DIRECTION;
            s_r.regs.pc_high_latch <= `RST_ZERO;
            s_r.regs.peripheral_irq_enable <= `RST_ZERO;
            s_r.regs.timer2_period <= `RST_TIMER2_PERIOD;
            s_r.regs.serial_slave_address <= `RST_ZERO;
            if (kind == sfr_bank1_pkg::RST_OTHER) begin
                s_r.regs.core_status <= s_nxt.regs.core_status & `MASK_STATUS_OTHER;
                s_r.regs.interrupt_control <= s_nxt.regs.interrupt_control
                    & `INTERRUPT_CONTROL_RST_MASK;
                s_r.regs.indirect_pointer <= s_nxt.regs.indirect_pointer;
                s_r.regs.power_reset_status <= s_nxt.regs.power_reset_status;
            end else begin
                s_r.regs.core_status <= `RST_STATUS_POWER;
                s_r.regs.interrupt_control <= `RST_ZERO;
                s_r.regs.indirect_pointer <= `RST_ZERO;
                s_r.regs.power_reset_status <= (kind == sfr_bank1_pkg::RST_POWER)
                    ? 8'h01 : 8'h02;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    assign program_counter = s_r.pc;
    assign option_control = s_r.regs.option_control;
    assign port_a_direction = s_r.regs.port_a_direction;
    assign port_b_direction = s_r.regs.port_b_direction;
    assign port_c_direction = s_r.regs.port_c_direction;
    assign peripheral_irq_enable = s_r.regs.peripheral_irq_enable;
    assign timer2_period = s_r.regs.timer2_period;
    assign serial_slave_address = s_r.regs.serial_slave_address;

    a_pc_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_awready && s_axi_wstrb[0] && (s_axi_awaddr[8:2] == 7'h02))
        |=> program_counter == {$past(s_r.regs.pc_high_latch[4:0]), $past(s_axi_wdata[7:0])})
        else $error("pc not loaded from latch");
    a_pc_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !(s_axi_awready && s_axi_wstrb[0] && s_axi_awaddr[8:2] == 7'h02)
        |=> $stable(program_counter))
        else $error("pc changed without low byte load");
    a_bank_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arready && s_axi_araddr[8:2] == 7'h0a)
        |=> s_axi_rdata[7:0] == $past(s_r.regs.pc_high_latch))
        else $error("mirror read mismatch");
    a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arready && s_axi_araddr[9:2] == 8'h88) |=> s_axi_rdata == 32'h00000000)
        else $error("unimplemented index not zero");
    a_latch_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        s_r.regs.pc_high_latch[7:5] == 3'h0 && s_r.regs.port_a_direction[7:6] == 2'h0)
        else $error("unimplemented bits set");
    a_other_reset: assert property (@(posedge aclk)
        (!aresetn && !por_s2_r && !bor_s2_r) |=> s_r.regs.indirect_pointer
        == $past(s_nxt.regs.indirect_pointer))
        else $error("other reset lost pointer");
    a_ind_addr: assert property (@(posedge aclk) disable iff (!aresetn)
        mem_req.mem_req |-> mem_req.mem_addr == s_r.regs.indirect_pointer)
        else $error("indirect address wrong");
    a_ind_done: assert property (@(posedge aclk) disable iff (!aresetn)
        (mem_req.mem_req && mem_ack && mem_req.mem_we) |=> s_axi_bvalid)
        else $error("indirect write not answered");
endmodule

// *** testbench/sfr_bank1_decode_bench.sv ***
// Self-checking bench for the bank-one register file and its bus slave.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
module sfr_bank1_decode_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic power_on_reset = 1'b1;
    logic brownout_reset = 1'b0;
    logic [9:0] awaddr = 10'h000;
    logic [9:0] araddr = 10'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    sfr_bank1_pkg::mem_req_s mem_req, last_req;
    logic mem_ack = 1'b0;
    logic [7:0] mem_rdata = 8'h00;
    logic [7:0] serial_status = 8'hea;
    logic [12:0] program_counter;
    logic [7:0] option_control, port_a_direction, port_b_direction, port_c_direction;
    logic [7:0] peripheral_irq_enable, timer2_period, serial_slave_address;
    int num_errors = 0;
    int checks = 0;

    sfr_bank1_decode sfr_bank1_decode_inst (.aclk(aclk), .aresetn(aresetn),
        .power_on_reset(power_on_reset), .brownout_reset(brownout_reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .serial_status(serial_status),
        .program_counter(program_counter), .option_control(option_control),
        .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
        .port_c_direction(port_c_direction), .peripheral_irq_enable(peripheral_irq_enable),
        .timer2_period(timer2_period), .serial_slave_address(serial_slave_address));

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    // Data memory: one-cycle ack, read data derived from the address
    always @(posedge aclk) begin
        mem_ack <= mem_req.mem_req && !mem_ack;
        mem_rdata <= ~mem_req.mem_addr;
        if (mem_req.mem_req && !mem_ack) begin
            last_req <= mem_req;
        end
    end

    task automatic fail(input string what);
        num_errors++;
        $display("[FAIL] %0t %s", $time, what);
    endtask

    task automatic chk_port(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail($sformatf("%s got %h exp %h", what, got, exp));
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1) && ++n < 100);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        if (n >= 100) begin
            fail("write address not taken");
        end
        n = 0;
        do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 100);
        bready <= 1'b0;
        if (n >= 100) begin
            fail("write response missing");
        end
        chk_port({14'h0000, bresp}, 16'h0000, "write resp");
    endtask

    task automatic chk_rd(input logic [7:0] idx, input logic [7:0] exp);
        int n;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do @(posedge aclk); while (arready !== 1'b1 && ++n < 100);
        arvalid <= 1'b0;
        if (n >= 100) begin
            fail("read address not taken");
        end
        n = 0;
        do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) begin
            fail("read response missing");
        end
        checks++;
        if (d !== {24'h000000, exp} || r !== 2'b00) begin
            fail($sformatf("read %h got %h resp %b exp %h", idx, d, r, exp));
        end
    endtask

    task automatic do_reset(input logic por, input logic bor);
        @(posedge aclk);
        power_on_reset <= por;
        brownout_reset <= bor;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        power_on_reset <= 1'b0;
        brownout_reset <= 1'b0;
    endtask

    task automatic t_reset_values;
        chk_rd(8'h81, 8'hff);
        chk_rd(8'h82, 8'h00);
        chk_rd(8'h83, 8'h18);
        chk_rd(8'h85, 8'h3f);
        chk_rd(8'h86, 8'hff);
        chk_rd(8'h87, 8'hff);
        chk_rd(8'h8a, 8'h00);
        chk_rd(8'h8c, 8'h00);
        chk_rd(8'h8e, 8'h01);
        chk_rd(8'h92, 8'hff);
        chk_rd(8'h93, 8'h00);
        chk_rd(8'ha0, 8'h01);
        chk_port({option_control, timer2_period}, 16'hffff, "option/period");
        chk_port({port_a_direction, port_c_direction}, 16'h3fff, "direction");
        chk_port({port_b_direction, serial_slave_address}, 16'hff00, "port b/serial addr");
    endtask

    task automatic t_pc_load;
        wr(8'h8a, 8'h15);
        chk_port({3'b000, program_counter}, 16'h0000, "pc before low write");
        wr(8'h82, 8'h34);
        chk_port({3'b000, program_counter}, 16'h1534, "pc after low write");
        chk_rd(8'h82, 8'h34);
        wr(8'h8a, 8'hff);
        chk_rd(8'h8a, 8'h1f);
        wr(8'h02, 8'h00);
        chk_port({3'b000, program_counter}, 16'h1f00, "pc via bank zero");
    endtask

    task automatic t_mirror_unimpl;
        wr(8'h04, 8'h40);
        chk_rd(8'h84, 8'h40);
        wr(8'h8b, 8'h81);
        chk_rd(8'h0b, 8'h81);
        wr(8'h88, 8'hff);
        chk_rd(8'h88, 8'h00);
        chk_rd(8'h8d, 8'h00);
        chk_rd(8'h91, 8'h00);
        chk_rd(8'h9f, 8'h00);
        wr(8'h85, 8'hff);
        chk_rd(8'h85, 8'h3f);
        wr(8'h94, 8'hff);
        chk_rd(8'h94, 8'h2a);
        wr(8'h8c, 8'h3f);
        chk_port({8'h00, peripheral_irq_enable}, 16'h003f, "irq enable");
    endtask

    task automatic t_indirect;
        wr(8'h80, 8'h5a);
        chk_port({last_req.mem_we, last_req.mem_addr, last_req.mem_wdata},
            {1'b1, 8'h40, 8'h5a}, "indirect write");
        chk_rd(8'h80, 8'hbf);
        chk_port({8'h00, last_req.mem_we, last_req.mem_addr}, {8'h00, 1'b0, 8'h40},
            "indirect read");
    endtask

    task automatic t_reset_kinds;
        wr(8'h81, 8'h12);
        wr(8'h83, 8'h05);
        wr(8'h8e, 8'h03);
        do_reset(1'b0, 1'b0);
        chk_rd(8'h81, 8'hff);
        chk_rd(8'h84, 8'h40);
        chk_rd(8'h8e, 8'h03);
        chk_rd(8'h8a, 8'h00);
        chk_rd(8'ha0, 8'h02);
        do_reset(1'b0, 1'b1);
        chk_rd(8'ha0, 8'h03);
        chk_rd(8'h8e, 8'h02);
        do_reset(1'b1, 1'b0);
        chk_rd(8'ha0, 8'h01);
        chk_rd(8'h8e, 8'h01);
    endtask

    task automatic conclude;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        fail("watchdog expired");
        conclude();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        power_on_reset <= 1'b0;
        t_reset_values();
        t_pc_load();
        t_mirror_unimpl();
        t_indirect();
        t_reset_kinds();
        conclude();
    end
endmodule
